//--- link_partner_model.sv
// Behavioural remote link partner driving page, polarity and activity inputs.
`timescale 1ns/1ps
`default_nettype none
module link_partner_model
	import phy_regs_pkg::*;
(
	input wire logic clk,
	output var base_page_s page_in,
	output logic page_valid,
	output logic autoneg_seen,
	output logic reversed,
	output logic activity
);
	initial begin
		page_in = '0;
		page_valid = 1'b0;
		autoneg_seen = 1'b0;
		reversed = 1'b0;
		activity = 1'b1;
	end
	// The page lines are inverted once released so a stale value cannot pass.
	task automatic send_page(input base_page_s p);
		@(negedge clk);
		page_in = p;
		page_valid = 1'b1;
		autoneg_seen = 1'b1;
		@(negedge clk);
		page_valid = 1'b0;
		autoneg_seen = 1'b0;
		page_in = ~p;
	endtask
	task automatic set_line(input logic rv, input logic ac);
		@(negedge clk);
		reversed = rv;
		activity = ac;
	endtask
endmodule // link_partner_model
`default_nettype wire

//--- phy_autoneg_partner_and_vendor_regs.sv
// Partner base page, expansion and vendor mode registers of the PHY management set.
// Function
// - Read-only partner ability register at 0x05.
// - Bit 15 shows partner next page capable.
// - Bit 14 shows partner page received.
// - Bit 13 shows partner remote fault.
// - Bits 12:5 hold partner technology abilities.
// - Bits 4:0 hold partner selector code.
// - Expansion register 0x06, bit 0 partner autoneg.
// - Vendor register 0x10 resets to 0x0140.
// - Bit 5 disables automatic polarity correction.
// - Auto-invert reversed polarity in 10Base-T.
// - Bit 4 reads inversion status when enabled.
// - Bit 4 forces inversion when correction disabled.
// - Bits 3:2 reserved, read zero, preserved.
// - Bit 1 bypasses coding sublayer in 100Base-TX.
// - Bit 0 gates idle receive clock, 100Base-TX.
// - Loopback suppresses receive clock gating.
`timescale 1ns/1ps
`default_nettype none
module phy_autoneg_partner_and_vendor_regs
	import phy_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire mgmt_req_s mgmt_req,
	output logic [15:0] mgmt_rdata,
	output logic mgmt_rvalid,
	input wire logic page_valid,
	input wire base_page_s page_in,
	input wire logic autoneg_restart,
	input wire logic partner_autoneg_seen,
	input wire speed_e speed,
	input wire logic loopback_control,
	input wire logic rx_activity_pin,
	input wire logic reversed_polarity_pin,
	output logic receive_polarity_inverted,
	output logic pcs_bypass_active,
	output logic scrambler_bypass_active,
	output logic rx_clock_enable
);

	typedef struct packed {
		base_page_s partner;
		logic partner_can_autoneg;
		vendor_ctrl_s ctrl;
		logic [15:0] rdata;
		logic rvalid;
		logic bypass;
		logic clk_en;
	} regs_state_s;

	regs_state_s s_q;
	regs_state_s s_d;
	logic [1:0] rst_sync_q;
	logic rst_core_n;
	logic rx_activity;
	logic reversed_seen;
	logic invert;
	logic is_100tx;
	logic [15:0] vendor_view;

	// Reset release is synchronised so that every flop past these two leaves reset on the same edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	// The release flops sit outside the state struct because they run on the raw reset.
	assign rst_core_n = rst_sync_q[1];

	sync_2ff u_sync_activity (
		.clk(clk),
		.rst_n(rst_core_n),
		.d(rx_activity_pin),
		.q(rx_activity)
	);

	sync_2ff u_sync_reversed (
		.clk(clk),
		.rst_n(rst_core_n),
		.d(reversed_polarity_pin),
		.q(reversed_seen)
	);

	polarity_detect u_polarity (
		.clk(clk),
		.rst_n(rst_core_n),
		.reversed_seen(reversed_seen),
		.is_10base_t(speed == speed_10),
		.correction_disable(s_q.ctrl.polarity_correction_disable),
		.forced_polarity(s_q.ctrl.forced_polarity),
		.invert(invert)
	);

	assign is_100tx = (speed == speed_100);

	// Fixed upper bits, live controls and zero reserved bits as software sees them.
	always_comb begin
		vendor_view = {vendor_fixed_hi, 6'h00};
		vendor_view[bit_pol_disable] = s_q.ctrl.polarity_correction_disable;
		vendor_view[bit_pol_inverted] = invert;
		vendor_view[rsvd_hi:rsvd_lo] = 2'b00;
		vendor_view[bit_bypass] = s_q.ctrl.coding_sublayer_bypass;
		vendor_view[bit_clk_gating] = s_q.ctrl.receive_clock_gating;
	end

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;

		// A restart forgets the old partner; a fresh page in the same cycle still lands.
		if (autoneg_restart) begin
			s_d.partner = base_page_s'(partner_ability_reset);
			s_d.partner_can_autoneg = 1'b0;
		end
		if (page_valid) begin
			s_d.partner.next_page = page_in.next_page;
			s_d.partner.ack = 1'b1;
			s_d.partner.remote_fault = page_in.remote_fault;
			s_d.partner.tech = page_in.tech;
			s_d.partner.selector = page_in.selector;
		end
		if (partner_autoneg_seen) begin
			s_d.partner_can_autoneg = 1'b1;
		end

		// Only the vendor register takes writes; other addresses ignore them.
		if (mgmt_req.wr && mgmt_req.addr == addr_vendor_mode) begin
			s_d.ctrl.polarity_correction_disable = mgmt_req.wdata[bit_pol_disable];
			if (mgmt_req.wdata[bit_pol_disable]) begin
				s_d.ctrl.forced_polarity = mgmt_req.wdata[bit_pol_inverted];
			end else begin
				s_d.ctrl.forced_polarity = 1'b0;
			end
			s_d.ctrl.coding_sublayer_bypass = mgmt_req.wdata[bit_bypass];
			s_d.ctrl.receive_clock_gating = mgmt_req.wdata[bit_clk_gating];
		end

		if (mgmt_req.rd) begin
			s_d.rvalid = 1'b1;
			case (mgmt_req.addr)
				addr_partner_ability: begin
					s_d.rdata = s_q.partner;
				end
				addr_autoneg_expansion: begin
					s_d.rdata = expansion_reset;
					s_d.rdata[bit_partner_can_autoneg] = s_q.partner_can_autoneg;
				end
				addr_vendor_mode: begin
					s_d.rdata = vendor_view;
				end
				default: begin
					s_d.rdata = 16'h0000;
				end
			endcase
		end

		// Bypass is acted on only in 100Base-TX; software keeps it to forced 100M.
		s_d.bypass = s_q.ctrl.coding_sublayer_bypass && is_100tx;
		// Gating drops the clock only while idle, and never in loopback.
		s_d.clk_en = !(s_q.ctrl.receive_clock_gating && is_100tx
			&& !loopback_control && !rx_activity);
	end

	always_ff @(posedge clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			s_q.partner <= base_page_s'(partner_ability_reset);
			s_q.partner_can_autoneg <= 1'b0;
			s_q.ctrl <= {vendor_mode_reset[bit_pol_disable], vendor_mode_reset[bit_pol_inverted],
				vendor_mode_reset[bit_bypass], vendor_mode_reset[bit_clk_gating]};
			s_q.rdata <= 16'h0000;
			s_q.rvalid <= 1'b0;
			s_q.bypass <= 1'b0;
			s_q.clk_en <= 1'b1;
		end else begin
			s_q.partner <= s_d.partner;
			s_q.partner_can_autoneg <= s_d.partner_can_autoneg;
			s_q.ctrl <= s_d.ctrl;
			s_q.rdata <= s_d.rdata;
			s_q.rvalid <= s_d.rvalid;
			s_q.bypass <= s_d.bypass;
			s_q.clk_en <= s_d.clk_en;
		end
	end

	assign mgmt_rdata = s_q.rdata;
	assign mgmt_rvalid = s_q.rvalid;
	assign receive_polarity_inverted = invert;
	assign pcs_bypass_active = s_q.bypass;
	assign scrambler_bypass_active = s_q.bypass;
	assign rx_clock_enable = s_q.clk_en;

endmodule // phy_autoneg_partner_and_vendor_regs
`default_nettype wire

//--- phy_regs_pkg.sv
// Package with register map, field positions and carrier types for the partner and vendor registers.
package phy_regs_pkg;

	localparam logic [4:0] addr_partner_ability = 5'h05;
	localparam logic [4:0] addr_autoneg_expansion = 5'h06;
	localparam logic [4:0] addr_vendor_mode = 5'h10;

	localparam logic [15:0] partner_ability_reset = 16'h0000;
	localparam logic [15:0] expansion_reset = 16'h0000;
	localparam logic [15:0] vendor_mode_reset = 16'h0140;

	localparam int bit_next_page = 15;
	localparam int bit_ack = 14;
	localparam int bit_remote_fault = 13;
	localparam int tech_hi = 12;
	localparam int tech_lo = 5;
	localparam int sel_hi = 4;
	localparam int sel_lo = 0;
	localparam int bit_partner_can_autoneg = 0;
	localparam int bit_pol_disable = 5;
	localparam int bit_pol_inverted = 4;
	localparam int rsvd_hi = 3;
	localparam int rsvd_lo = 2;
	localparam int bit_bypass = 1;
	localparam int bit_clk_gating = 0;

	// Fixed bits 15:6 of the vendor register; they hold the reset pattern and are not writable.
	localparam logic [9:0] vendor_fixed_hi = 10'h005;

	localparam logic [4:0] sel_ieee_8023 = 5'h01;
	localparam logic [4:0] sel_ieee_8029 = 5'h02;
	localparam logic [4:0] sel_ieee_8025 = 5'h03;
	localparam logic [4:0] sel_ieee_1394 = 5'h04;

	typedef struct packed {
		logic next_page;
		logic ack;
		logic remote_fault;
		logic [7:0] tech;
		logic [4:0] selector;
	} base_page_s;

	typedef struct packed {
		logic polarity_correction_disable;
		logic forced_polarity;
		logic coding_sublayer_bypass;
		logic receive_clock_gating;
	} vendor_ctrl_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mgmt_req_s;

	typedef enum logic [1:0] {
		speed_10 = 2'b00,
		speed_100 = 2'b01,
		speed_other = 2'b10
	} speed_e;

endpackage

//--- phy_regs_properties.sv
// Checker for the partner page, expansion and vendor mode registers.
`timescale 1ns/1ps
`default_nettype none
module phy_regs_checker
	import phy_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire mgmt_req_s mgmt_req,
	input wire logic [15:0] mgmt_rdata,
	input wire logic mgmt_rvalid,
	input wire logic page_valid,
	input wire logic autoneg_restart,
	input wire speed_e speed,
	input wire logic loopback_control,
	input wire logic pcs_bypass_active,
	input wire logic rx_clock_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic r = mgmt_req.rd;
	wire logic [4:0] a = mgmt_req.addr;
	rd_answer_a: assert property (r |=> mgmt_rvalid)
		else $error("read not answered");
	rd_quiet_a: assert property (!r |=> !mgmt_rvalid)
		else $error("answer without read");
	unmapped_zero_a: assert property (
		r && !(a inside {5'h05, 5'h06, 5'h10}) |=> mgmt_rdata == 16'h0000)
		else $error("unmapped read not zero");
	vendor_fixed_a: assert property (
		r && a == addr_vendor_mode |=> mgmt_rdata[15:6] == vendor_fixed_hi && !mgmt_rdata[3:2])
		else $error("vendor fixed bits wrong");
	page_ack_a: assert property (
		page_valid ##1 !autoneg_restart ##1 (r && a == addr_partner_ability) |=> mgmt_rdata[14])
		else $error("page ack missing");
	bypass_speed_a: assert property (pcs_bypass_active |-> $past(speed) == speed_100)
		else $error("bypass outside 100 mode");
	loop_clock_a: assert property ($past(loopback_control) |-> rx_clock_enable)
		else $error("clock gated in loopback");
	gate_speed_a: assert property (!rx_clock_enable |-> $past(speed) == speed_100)
		else $error("clock gated outside 100 mode");
	cover property (page_valid);
	cover property (!rx_clock_enable);
	cover property (pcs_bypass_active);
endmodule // phy_regs_checker
bind phy_autoneg_partner_and_vendor_regs phy_regs_checker i_chk (.clk(clk), .rst_n(rst_n),
	.mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
	.page_valid(page_valid), .autoneg_restart(autoneg_restart), .speed(speed),
	.loopback_control(loopback_control),
	.pcs_bypass_active(pcs_bypass_active), .rx_clock_enable(rx_clock_enable));
`default_nettype wire

//--- polarity_detect.sv
// Receive polarity correction: decides whether received 10Base-T data is to be inverted.
`timescale 1ns/1ps
`default_nettype none
module polarity_detect
	import phy_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reversed_seen,
	input wire logic is_10base_t,
	input wire logic correction_disable,
	input wire logic forced_polarity,
	output logic invert
);

	typedef struct packed {
		logic auto_inv;
	} pol_state_s;

	pol_state_s s_q;
	pol_state_s s_d;

	// The automatic decision follows the synchronised detector level in 10Base-T only.
	// It is cleared in other speeds, so a stale decision never outlives a speed change.
	always_comb begin
		s_d = s_q;
		if (correction_disable || !is_10base_t) begin
			s_d.auto_inv = 1'b0;
		end else begin
			s_d.auto_inv = reversed_seen;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign invert = correction_disable ? forced_polarity : s_q.auto_inv;

endmodule // polarity_detect
`default_nettype wire

//--- sync_2ff.sv
// Two flip-flop synchroniser for a level coming from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff
	import phy_regs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);

	typedef struct packed {
		logic meta;
		logic sync;
	} sync_state_s;

	sync_state_s s_q;
	sync_state_s s_d;

	always_comb begin
		s_d.meta = d;
		s_d.sync = s_q.meta;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.sync;

endmodule // sync_2ff
`default_nettype wire

//--- test_phy_autoneg_partner_and_vendor_regs.sv
// Self-checking bench for the partner page, expansion and vendor mode registers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_phy_autoneg_partner_and_vendor_regs
	import phy_regs_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mgmt_req_s req;
	base_page_s pg, pin;
	speed_e speed;
	logic [15:0] rdata;
	logic [15:0] q[$];
	logic [15:0] exp_rd;
	logic rvalid, pv, restart, seen, rev, act, loop, pol, pcs, scr, rce;
	int err_count = 0;
	int checks = 0;
	int seed = 32'hc627;
	always #5 clk = ~clk;
	phy_autoneg_partner_and_vendor_regs i_dut (.clk(clk), .rst_n(rst_n), .mgmt_req(req),
		.mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .page_valid(pv), .page_in(pin),
		.autoneg_restart(restart), .partner_autoneg_seen(seen), .speed(speed),
		.loopback_control(loop), .rx_activity_pin(act), .reversed_polarity_pin(rev),
		.receive_polarity_inverted(pol), .pcs_bypass_active(pcs),
		.scrambler_bypass_active(scr), .rx_clock_enable(rce));
	link_partner_model i_lp (.clk(clk), .page_in(pin), .page_valid(pv),
		.autoneg_seen(seen), .reversed(rev), .activity(act));
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			exp_rd = q.pop_front();
			`CHK(rdata, exp_rd)
		end
	end
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(negedge clk);
		req.rd = 1'b1;
		req.addr = a;
		q.push_back(e);
		@(negedge clk);
		req.rd = 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(negedge clk);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		@(negedge clk);
		req.wr = 1'b0;
	endtask
	task automatic complete_run;
		$display("err_count=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		complete_run();
	end
	initial begin
		req = '0;
		restart = 1'b0;
		speed = speed_10;
		loop = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		rd(addr_partner_ability, partner_ability_reset);
		rd(addr_autoneg_expansion, expansion_reset);
		rd(addr_vendor_mode, vendor_mode_reset);
		wr(addr_partner_ability, 16'hffff);
		wr(addr_autoneg_expansion, 16'hffff);
		wr(5'h1f, 16'hffff);
		rd(addr_partner_ability, 16'h0000);
		rd(addr_autoneg_expansion, 16'h0000);
		rd(5'h1f, 16'h0000);
		for (int s = 1; s <= 4; s++) begin
			pg = 16'($random(seed));
			pg.selector = 5'(s);
			pg.next_page = s[0];
			pg.remote_fault = ~s[0];
			pg.ack = 1'b0;
			i_lp.send_page(pg);
			pg.ack = 1'b1;
			rd(addr_partner_ability, pg);
		end
		rd(addr_autoneg_expansion, 16'h0001);
		@(negedge clk);
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
		rd(addr_partner_ability, 16'h0000);
		rd(addr_autoneg_expansion, 16'h0000);
		wr(addr_vendor_mode, 16'hfff1);
		rd(addr_vendor_mode, 16'h0171);
		`CHK(pol, 1'b1)
		`CHK(pcs, 1'b0)
		`CHK(rce, 1'b1)
		speed = speed_100;
		wr(addr_vendor_mode, 16'h0032);
		repeat (2) @(negedge clk);
		`CHK(pcs, 1'b1)
		`CHK(scr, 1'b1)
		wr(addr_vendor_mode, 16'h0001);
		i_lp.set_line(1'b0, 1'b0);
		repeat (5) @(negedge clk);
		`CHK(rce, 1'b0)
		`CHK(pol, 1'b0)
		`CHK(scr, 1'b0)
		loop = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(rce, 1'b1)
		loop = 1'b0;
		// A bit 4 write with auto correction on must not stick.
		wr(addr_vendor_mode, 16'h0010);
		speed = speed_10;
		i_lp.set_line(1'b1, 1'b1);
		repeat (5) @(negedge clk);
		`CHK(pol, 1'b1)
		`CHK(rce, 1'b1)
		rd(addr_vendor_mode, 16'h0150);
		speed = speed_100;
		repeat (3) @(negedge clk);
		`CHK(pol, 1'b0)
		rd(addr_vendor_mode, 16'h0140);
		// A speed that is neither 10Base-T nor 100Base-TX keeps the clock running and the data uninverted.
		wr(addr_vendor_mode, 16'h0001);
		speed = speed_other;
		i_lp.set_line(1'b1, 1'b0);
		repeat (5) @(negedge clk);
		`CHK(rce, 1'b1)
		`CHK(pol, 1'b0)
		repeat (3) @(negedge clk);
		`CHK(q.size(), 0)
		complete_run();
	end
endmodule // test_phy_autoneg_partner_and_vendor_regs
`default_nettype wire
